// [eci_pkg.sv]
package eci_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_PIN_ENV2      = 8'h00;
	localparam logic [7:0] ADDR_CNT_ENV3      = 8'h04;
	localparam logic [7:0] ADDR_CMP_ENV4      = 8'h08;
	localparam logic [7:0] ADDR_EXT_ERR_STAT  = 8'h0c;
	localparam logic [7:0] ADDR_DEFL_LIMIT    = 8'h10;
	localparam logic [7:0] ADDR_CMP4_LIMIT    = 8'h14;
	localparam logic [7:0] ADDR_EVENT_MASK    = 8'h18;
	localparam logic [7:0] ADDR_EVENT_STATUS  = 8'h1c;
	localparam logic [7:0] ADDR_COMMAND       = 8'h20;
	localparam logic [7:0] ADDR_DEFL_COUNT    = 8'h24;
	localparam logic [7:0] ADDR_GP_COUNT      = 8'h28;
	// field positions
	localparam int ENC_MODE_LSB  = 20;
	localparam int ENC_DIR_BIT   = 22;
	localparam int PIN_FUNC_LSB  = 12;
	localparam int GP_SEL_LSB    = 12;
	localparam int C4_SEL_LSB    = 24;
	localparam int C4_METH_LSB   = 26;
	localparam int IDX_MODE_BIT  = 23;
	localparam int ERR_FLAG_BIT  = 16;
	localparam int EV_C3_BIT     = 10;
	localparam int EV_ERR_BIT    = 16;
	// codes
	localparam logic [7:0] CMD_DEFL_CLEAR = 8'h22;
	localparam logic [1:0] ENC_X1 = 2'h0;
	localparam logic [1:0] ENC_X2 = 2'h1;
	localparam logic [1:0] ENC_X4 = 2'h2;
	localparam logic [1:0] ENC_PULSE = 2'h3;
	localparam logic [1:0] GP_OUT = 2'h0;
	localparam logic [1:0] GP_ENC = 2'h1;
	localparam logic [1:0] GP_MAN = 2'h2;
	localparam logic [1:0] GP_CLK2 = 2'h3;
	localparam logic [1:0] PIN_IDX_LOW  = 2'h2;
	localparam logic [1:0] PIN_IDX_HIGH = 2'h3;
	localparam logic [1:0] C4_SEL_GP = 2'h3;
	localparam logic [3:0] C4_IDX_ANY  = 4'h8;
	localparam logic [3:0] C4_IDX_UP   = 4'h9;
	localparam logic [3:0] C4_IDX_DOWN = 4'ha;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [1:0] IDX_PULSE_CYC = 2'h2;
	typedef struct packed {
		logic a;
		logic b;
	} eci_pair_t;
	typedef struct packed {
		logic up;
		logic dn;
	} eci_step_t;
	typedef enum logic [1:0] {AXI_OKAY = 2'h0, AXI_SLVERR = 2'h2} eci_resp_t;
endpackage : eci_pkg

// [eci_top.sv]
`timescale 1ns/1ns
// How it works
// - encoder pair decoded by 2-bit mode: 1x, 2x, 4x quadrature, or up/down pulses
// - direction bit picks which phase leading or rising counts up
// - encoder error flag readable in status register, 1 once an error seen
// - both phases changing together outside pulse mode is an error and raises the low interrupt when its enable bit is set
// - deflection counter tracks commanded up pulses minus feedback up steps for out-of-step detect
// - command code 22h clears the deflection counter
// - interrupt when comparator 3 satisfied and its enable bit set
// - index output on shared pin from comparator 4 and general counter
// - in index use the general counter wraps between zero and the limit
// - general counter input: output pulses, encoder, manual pulser, clock/2
// - terminal function 10 drives index low-active, 11 high-active
// - comparator 4 select 11 picks the general counter
// - method 1000 any direction, 1001 up only, 1010 down only
// - level mode holds index while counter equals limit
// - pulse mode gives two clocks of index when counting reaches zero
// - pulse mode gives no index when zero is written or counter reset
// - index mode bit matters only with an index method code
module eci_top #(
	parameter int CW = 32
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        encoder_phase_a,
	input  wire logic        encoder_phase_b,
	input  wire logic [1:0]  manual_pulser_inputs,
	input  wire logic        cmd_pulse,
	input  wire logic        cmd_dir_neg,
	output logic             shared_general_compare_pin,
	output logic             irq_n
);
	// ---------------- synchronisers: three stages, change once stages 2 and 3 agree
	logic [3:0] sync1_r, sync2_r, sync3_r, filt_r;
	wire  [3:0] pins_in = {manual_pulser_inputs, encoder_phase_b, encoder_phase_a};
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= 4'h0;
			sync2_r <= 4'h0;
			sync3_r <= 4'h0;
			filt_r  <= 4'h0;
		end else begin
			sync1_r <= pins_in;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			filt_r  <= (sync2_r & sync3_r) | (filt_r & (sync2_r | sync3_r));
		end
	end
	// previous filtered value for edge detection
	logic [3:0] prev_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) prev_r <= 4'h0;
		else prev_r <= filt_r;
	end

	// ---------------- registers
	logic [31:0] env2_r, env3_r, env4_r, defl_lim_r, c4_lim_r, mask_r, evst_r;
	logic        err_flag_r;
	wire [1:0] enc_mode  = env2_r[eci_pkg::ENC_MODE_LSB +: 2];
	wire       enc_dir   = env2_r[eci_pkg::ENC_DIR_BIT];
	wire [1:0] pin_func  = env2_r[eci_pkg::PIN_FUNC_LSB +: 2];
	wire [1:0] gp_sel    = env3_r[eci_pkg::GP_SEL_LSB +: 2];
	wire [1:0] c4_sel    = env4_r[eci_pkg::C4_SEL_LSB +: 2];
	wire [3:0] c4_meth   = env4_r[eci_pkg::C4_METH_LSB +: 4];
	wire       idx_mode  = env4_r[eci_pkg::IDX_MODE_BIT];

	// ---------------- quadrature / pulse decode
	function automatic eci_pkg::eci_step_t decode(input logic [1:0] mode, input logic dir,
		input eci_pkg::eci_pair_t cur, input eci_pkg::eci_pair_t old);
		eci_pkg::eci_step_t s;
		logic ea_r, ea_f, eb_r, eb_f, fwd, rev;
		s = '0;
		ea_r = cur.a & ~old.a;
		ea_f = ~cur.a & old.a;
		eb_r = cur.b & ~old.b;
		eb_f = ~cur.b & old.b;
		// forward means phase a leads
		fwd = (ea_r & ~cur.b) | (ea_f & cur.b) | (eb_r & cur.a) | (eb_f & ~cur.a);
		rev = (ea_r & cur.b) | (ea_f & ~cur.b) | (eb_r & ~cur.a) | (eb_f & cur.a);
		case (mode)
			eci_pkg::ENC_X4: begin
				s.up = fwd;
				s.dn = rev;
			end
			eci_pkg::ENC_X2: begin
				s.up = fwd & (ea_r | ea_f);
				s.dn = rev & (ea_r | ea_f);
			end
			eci_pkg::ENC_X1: begin
				s.up = fwd & ea_r;
				s.dn = rev & ea_f;
			end
			default: begin
				s.up = ea_r;
				s.dn = eb_r;
			end
		endcase
		if (dir) s = '{up: s.dn, dn: s.up};
		return s;
	endfunction : decode

	wire eci_pkg::eci_pair_t enc_cur = '{a: filt_r[0], b: filt_r[1]};
	wire eci_pkg::eci_pair_t enc_old = '{a: prev_r[0], b: prev_r[1]};
	wire eci_pkg::eci_pair_t man_cur = '{a: filt_r[2], b: filt_r[3]};
	wire eci_pkg::eci_pair_t man_old = '{a: prev_r[2], b: prev_r[3]};
	wire eci_pkg::eci_step_t enc_step = decode(enc_mode, enc_dir, enc_cur, enc_old);
	// an error step still decodes as a count, so the deflection counter can drift after a glitch
	wire eci_pkg::eci_step_t man_step = decode(eci_pkg::ENC_X4, 1'b0, man_cur, man_old);
	// pulse mode has two independent inputs, so a joint change is not an error there
	wire enc_err = (enc_mode != eci_pkg::ENC_PULSE) && (enc_cur.a != enc_old.a) && (enc_cur.b != enc_old.b);

	// commanded pulse edge, same clock domain
	logic cmd_prev_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) cmd_prev_r <= 1'b0;
		else cmd_prev_r <= cmd_pulse;
	end
	wire cmd_edge = cmd_pulse & ~cmd_prev_r;
	wire eci_pkg::eci_step_t out_step = '{up: cmd_edge & ~cmd_dir_neg, dn: cmd_edge & cmd_dir_neg};

	// ---------------- axi write path
	logic        aw_hold_r, w_hold_r;
	logic [7:0]  awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take  = s_axi_wvalid & s_axi_wready;
	wire wr_fire = aw_hold_r & w_hold_r & ~s_axi_bvalid;
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
		logic [31:0] m;
		m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
		return (old & ~m) | (d & m);
	endfunction : merge
	wire wr_env2  = wr_fire && awaddr_r == eci_pkg::ADDR_PIN_ENV2;
	wire wr_env3  = wr_fire && awaddr_r == eci_pkg::ADDR_CNT_ENV3;
	wire wr_env4  = wr_fire && awaddr_r == eci_pkg::ADDR_CMP_ENV4;
	wire wr_dlim  = wr_fire && awaddr_r == eci_pkg::ADDR_DEFL_LIMIT;
	wire wr_c4lim = wr_fire && awaddr_r == eci_pkg::ADDR_CMP4_LIMIT;
	wire wr_mask  = wr_fire && awaddr_r == eci_pkg::ADDR_EVENT_MASK;
	wire wr_evst  = wr_fire && awaddr_r == eci_pkg::ADDR_EVENT_STATUS;
	wire wr_cmd   = wr_fire && awaddr_r == eci_pkg::ADDR_COMMAND && wstrb_r[0];
	wire wr_dcnt  = wr_fire && awaddr_r == eci_pkg::ADDR_DEFL_COUNT;
	wire wr_gcnt  = wr_fire && awaddr_r == eci_pkg::ADDR_GP_COUNT;
	wire wr_ok    = wr_env2 | wr_env3 | wr_env4 | wr_dlim | wr_c4lim | wr_mask | wr_evst |
	                (wr_fire && awaddr_r == eci_pkg::ADDR_COMMAND) | wr_dcnt | wr_gcnt;
	wire defl_clr = wr_cmd && wdata_r[7:0] == eci_pkg::CMD_DEFL_CLEAR;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			awaddr_r  <= 8'h00;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end else begin
			if (aw_take) begin
				aw_hold_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
			end else if (wr_fire) aw_hold_r <= 1'b0;
			if (w_take) begin
				w_hold_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end else if (wr_fire) w_hold_r <= 1'b0;
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? eci_pkg::AXI_OKAY : eci_pkg::AXI_SLVERR;
			end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
		end
	end
	assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_hold_r & ~s_axi_bvalid;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			env2_r     <= eci_pkg::RST_ZERO;
			env3_r     <= eci_pkg::RST_ZERO;
			env4_r     <= eci_pkg::RST_ZERO;
			defl_lim_r <= eci_pkg::RST_ZERO;
			c4_lim_r   <= eci_pkg::RST_ZERO;
			mask_r     <= eci_pkg::RST_ZERO;
		end else begin
			if (wr_env2) env2_r <= merge(env2_r, wdata_r, wstrb_r);
			if (wr_env3) env3_r <= merge(env3_r, wdata_r, wstrb_r);
			if (wr_env4) env4_r <= merge(env4_r, wdata_r, wstrb_r);
			if (wr_dlim) defl_lim_r <= merge(defl_lim_r, wdata_r, wstrb_r);
			if (wr_c4lim) c4_lim_r <= merge(c4_lim_r, wdata_r, wstrb_r);
			if (wr_mask) mask_r <= merge(mask_r, wdata_r, wstrb_r);
		end
	end

	// ---------------- deflection counter
	logic [CW-1:0] defl_r;
	// commanded up and feedback up cancel, so the counter holds the lag
	wire [CW-1:0] defl_nxt = defl_clr ? '0 : wr_dcnt ? wdata_r[CW-1:0] :
		((out_step.up & ~enc_step.up) ? defl_r + 1'b1 :
		 (~out_step.up & enc_step.up) ? defl_r - 1'b1 : defl_r);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) defl_r <= '0;
		else defl_r <= defl_nxt;
	end
	wire [CW-1:0] defl_mag = defl_r[CW-1] ? -defl_r : defl_r;
	wire c3_hit = defl_mag > defl_lim_r[CW-1:0];

	// ---------------- general purpose counter
	logic [CW-1:0] gp_r;
	logic          div2_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) div2_r <= 1'b0;
		else div2_r <= ~div2_r;
	end
	wire eci_pkg::eci_step_t gp_step =
		(gp_sel == eci_pkg::GP_OUT) ? out_step :
		(gp_sel == eci_pkg::GP_ENC) ? enc_step :
		(gp_sel == eci_pkg::GP_MAN) ? man_step : eci_pkg::eci_step_t'{up: div2_r, dn: 1'b0};
	wire idx_meth = c4_meth == eci_pkg::C4_IDX_ANY || c4_meth == eci_pkg::C4_IDX_UP ||
	                c4_meth == eci_pkg::C4_IDX_DOWN;
	wire idx_on   = idx_meth && c4_sel == eci_pkg::C4_SEL_GP;
	wire [CW-1:0] lim = c4_lim_r[CW-1:0];
	wire gp_inc = gp_step.up & ~gp_step.dn;
	wire gp_dec = gp_step.dn & ~gp_step.up;
	wire [CW-1:0] gp_cnt_nxt =
		gp_inc ? ((idx_on && gp_r == lim) ? '0 : gp_r + 1'b1) :
		gp_dec ? ((idx_on && gp_r == '0) ? lim : gp_r - 1'b1) : gp_r;
	wire [CW-1:0] gp_nxt = wr_gcnt ? wdata_r[CW-1:0] : gp_cnt_nxt;
	logic last_up_r;
	// include this cycle's step, else a one-way method judges the step that lands on the limit by the one before
	wire  last_up_nxt = gp_inc ? 1'b1 : gp_dec ? 1'b0 : last_up_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gp_r      <= '0;
			last_up_r <= 1'b1;
		end else begin
			gp_r <= gp_nxt;
			last_up_r <= last_up_nxt;
		end
	end
	wire dir_ok = (c4_meth == eci_pkg::C4_IDX_ANY) ||
	              (c4_meth == eci_pkg::C4_IDX_UP && last_up_nxt) ||
	              (c4_meth == eci_pkg::C4_IDX_DOWN && !last_up_nxt);
	// counting to zero only; a write of zero never reaches this term
	wire reach_zero = !wr_gcnt && (gp_inc | gp_dec) && gp_cnt_nxt == '0 &&
	                  (c4_meth == eci_pkg::C4_IDX_ANY || (c4_meth == eci_pkg::C4_IDX_UP && gp_inc) ||
	                   (c4_meth == eci_pkg::C4_IDX_DOWN && gp_dec));
	logic [1:0] pulse_cnt_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) pulse_cnt_r <= 2'h0;
		else if (idx_on && idx_mode && reach_zero) pulse_cnt_r <= eci_pkg::IDX_PULSE_CYC;
		else if (pulse_cnt_r != 2'h0) pulse_cnt_r <= pulse_cnt_r - 2'h1;
	end
	// level mode looks at the next count so the pin lines up with the counter register
	wire idx_level = idx_on && !idx_mode && gp_nxt == lim && dir_ok;
	wire idx_nxt   = idx_level | (idx_on && idx_mode && (reach_zero || pulse_cnt_r == 2'h2));
	wire pin_nxt   = (pin_func == eci_pkg::PIN_IDX_LOW) ? ~idx_nxt :
	                 (pin_func == eci_pkg::PIN_IDX_HIGH) ? idx_nxt : 1'b0;
	logic index_signal_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			index_signal_r <= 1'b0;
			shared_general_compare_pin <= 1'b0;
		end else begin
			index_signal_r <= idx_nxt;
			shared_general_compare_pin <= pin_nxt;
		end
	end

	// ---------------- events: set wins over write-one-clear
	wire [31:0] ev_set = ({31'h0, c3_hit} << eci_pkg::EV_C3_BIT) | ({31'h0, enc_err} << eci_pkg::EV_ERR_BIT);
	wire [31:0] ev_clr = wr_evst ? (wdata_r & {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}}) : 32'h0;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			evst_r     <= eci_pkg::RST_ZERO;
			err_flag_r <= 1'b0;
			irq_n      <= 1'b1;
		end else begin
			evst_r <= (evst_r & ~ev_clr) | ev_set;
			if (enc_err) err_flag_r <= 1'b1;
			irq_n  <= ~|(((evst_r & ~ev_clr) | ev_set) & mask_r);
		end
	end

	// ---------------- axi read path
	wire [31:0] rd_mux =
		(s_axi_araddr == eci_pkg::ADDR_EXT_ERR_STAT) ? ({31'h0, err_flag_r} << eci_pkg::ERR_FLAG_BIT) :
		(s_axi_araddr == eci_pkg::ADDR_DEFL_LIMIT)   ? defl_lim_r :
		(s_axi_araddr == eci_pkg::ADDR_CMP4_LIMIT)   ? c4_lim_r :
		(s_axi_araddr == eci_pkg::ADDR_EVENT_MASK)   ? mask_r :
		(s_axi_araddr == eci_pkg::ADDR_EVENT_STATUS) ? evst_r :
		(s_axi_araddr == eci_pkg::ADDR_DEFL_COUNT)   ? 32'(defl_r) :
		(s_axi_araddr == eci_pkg::ADDR_GP_COUNT)     ? 32'(gp_r) : 32'h0;
	wire rd_ok = s_axi_araddr inside {eci_pkg::ADDR_EXT_ERR_STAT, eci_pkg::ADDR_DEFL_LIMIT,
		eci_pkg::ADDR_CMP4_LIMIT, eci_pkg::ADDR_EVENT_MASK, eci_pkg::ADDR_EVENT_STATUS,
		eci_pkg::ADDR_DEFL_COUNT, eci_pkg::ADDR_GP_COUNT};
	wire ar_take = s_axi_arvalid & s_axi_arready;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'h0;
		end else if (ar_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= rd_ok ? eci_pkg::AXI_OKAY : eci_pkg::AXI_SLVERR;
		end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
	end
	assign s_axi_arready = ~s_axi_rvalid;

	// ---------------- checks
	property p_err_sticky;
		@(posedge clk) disable iff (!rst_n) enc_err |=> err_flag_r;
	endproperty
	a_err_sticky: assert property (p_err_sticky) else $error("error flag not set");
	property p_clr_defl;
		@(posedge clk) disable iff (!rst_n) defl_clr |=> defl_r == '0;
	endproperty
	a_clr_defl: assert property (p_clr_defl) else $error("deflection not cleared");
	property p_irq_err;
		@(posedge clk) disable iff (!rst_n) (enc_err && mask_r[eci_pkg::EV_ERR_BIT]) |=> !irq_n;
	endproperty
	a_irq_err: assert property (p_irq_err) else $error("no interrupt on encoder error");
	property p_irq_c3;
		@(posedge clk) disable iff (!rst_n) (c3_hit && mask_r[eci_pkg::EV_C3_BIT]) |=> !irq_n;
	endproperty
	a_irq_c3: assert property (p_irq_c3) else $error("no interrupt on comparator 3");
	property p_wrap;
		@(posedge clk) disable iff (!rst_n) (idx_on && !wr_gcnt && gp_r <= lim) |=> gp_r <= $past(lim);
	endproperty
	a_wrap: assert property (p_wrap) else $error("general counter left its range");
	property p_level;
		@(posedge clk) disable iff (!rst_n) (idx_on && !idx_mode && c4_meth == eci_pkg::C4_IDX_ANY && gp_nxt == lim)
			|=> index_signal_r;
	endproperty
	a_level: assert property (p_level) else $error("level index missing");
	property p_oneway_up;
		@(posedge clk) disable iff (!rst_n) (idx_on && !idx_mode && c4_meth == eci_pkg::C4_IDX_UP && gp_dec)
			|=> !index_signal_r;
	endproperty
	a_oneway_up: assert property (p_oneway_up) else $error("index while counting down in up-only method");
	property p_pulse2;
		@(posedge clk) disable iff (!rst_n) (idx_on && idx_mode && reach_zero && pulse_cnt_r == 2'h0)
			|=> index_signal_r [*2];
	endproperty
	a_pulse2: assert property (p_pulse2) else $error("index pulse not two cycles");
	property p_nowrite_pulse;
		@(posedge clk) disable iff (!rst_n) (idx_mode && wr_gcnt && pulse_cnt_r == 2'h0 && !index_signal_r)
			|=> !index_signal_r;
	endproperty
	a_nowrite_pulse: assert property (p_nowrite_pulse) else $error("index pulse on write");
	property p_pin_pol;
		@(posedge clk) disable iff (!rst_n) ($past(pin_func) == eci_pkg::PIN_IDX_HIGH && $past(pin_func, 2) == eci_pkg::PIN_IDX_HIGH)
			|-> shared_general_compare_pin == index_signal_r;
	endproperty
	a_pin_pol: assert property (p_pin_pol) else $error("pin polarity wrong");
	c_pulse: cover property (@(posedge clk) disable iff (!rst_n) idx_on && idx_mode && reach_zero);
	c_err: cover property (@(posedge clk) disable iff (!rst_n) enc_err);
	c_clr: cover property (@(posedge clk) disable iff (!rst_n) defl_clr);
	c_wrap_dn: cover property (@(posedge clk) disable iff (!rst_n) idx_on && gp_dec && gp_r == '0);
endmodule : eci_top

// [eci_enc_model.sv]
`timescale 1ns/1ns
module eci_enc_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       adv,
	input  wire logic       tog_a,
	input  wire logic       glitch,
	input  wire logic [3:0] lag,
	output logic            phase_a,
	output logic            phase_b
);
	// a slow encoder: the edge lands lag+1 cycles after the request is taken
	logic [1:0] pend_r;
	logic [3:0] cnt_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_r  <= 2'h0;
			cnt_r   <= 4'h0;
			phase_a <= 1'b0;
			phase_b <= 1'b0;
		end else if (adv | tog_a | glitch) begin
			pend_r <= glitch ? 2'h3 : (tog_a ? 2'h2 : 2'h1);
			cnt_r  <= lag;
		end else if (pend_r != 2'h0 && cnt_r != 4'h0) begin
			cnt_r <= cnt_r - 4'h1;
		end else if (pend_r != 2'h0) begin
			// forward quadrature: phase a leads, so 00 10 11 01
			pend_r  <= 2'h0;
			phase_a <= (pend_r == 2'h1) ? ~phase_b : ~phase_a;
			phase_b <= (pend_r == 2'h1) ? phase_a : ((pend_r == 2'h3) ? ~phase_b : phase_b);
		end
	end
endmodule : eci_enc_model

// [tb.sv]
`timescale 1ns/1ns
module tb;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        adv = 1'b0, tog_a = 1'b0, glitch = 1'b0, cmd_pulse = 1'b0, cmd_dir_neg = 1'b0;
	logic [3:0]  lag = 4'h3;
	logic [1:0]  pulser = 2'h0;
	logic        awready, wready, bvalid, arready, rvalid, ph_a, ph_b, pin, irq_n;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata, rd;
	int          num_errors = 0, checked = 0, hits = 0, cyc = 0;

	always #2 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	always @(posedge clk) if (pin === 1'b1) hits <= hits + 1;

	eci_enc_model enc_u (.clk(clk), .rst_n(rst_n), .adv(adv), .tog_a(tog_a), .glitch(glitch), .lag(lag),
		.phase_a(ph_a), .phase_b(ph_b));
	eci_top dut_u (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .encoder_phase_a(ph_a),
		.encoder_phase_b(ph_b), .manual_pulser_inputs(pulser), .cmd_pulse(cmd_pulse),
		.cmd_dir_neg(cmd_dir_neg), .shared_general_compare_pin(pin), .irq_n(irq_n));

	task automatic finish_test;
		if (num_errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// values read right after the edge are the ones sampled at that edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
		logic awd, wd;
		awd = 1'b0;
		wd = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(awd && wd)) begin
			@(posedge clk);
			if (!awd && awready === 1'b1) begin
				awd = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wd && wready === 1'b1) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge clk);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hffffffff,
		input logic [1:0] er = 2'h0);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		rd = rdata;
		chk(rdata & m, exp);
		chk({30'h0, rresp}, {30'h0, er});
	endtask : rdc

	task automatic cp(input logic neg, input int n);
		repeat (n) begin
			@(posedge clk);
			cmd_dir_neg <= neg;
			cmd_pulse <= 1'b1;
			@(posedge clk);
			cmd_pulse <= 1'b0;
			repeat (5) @(posedge clk);
		end
	endtask : cp

	task automatic es(input int kind, input int n);
		repeat (n) begin
			@(posedge clk);
			adv <= (kind == 0);
			tog_a <= (kind == 1);
			glitch <= (kind == 2);
			@(posedge clk);
			adv <= 1'b0;
			tog_a <= 1'b0;
			glitch <= 1'b0;
			repeat (12) @(posedge clk);
		end
	endtask : es

	task automatic pc(input logic e);
		repeat (4) @(posedge clk);
		chk({31'h0, pin}, {31'h0, e});
	endtask : pc

	task automatic t_regs;
		chk({31'h0, irq_n}, 32'h1);
		rdc(8'h0c, 32'h0);
		rdc(8'h04, 32'h0, 32'hffffffff, 2'h2);
		rdc(8'h3c, 32'h0, 32'hffffffff, 2'h2);
		wr(8'h3c, 32'h1, 2'h2);
	endtask : t_regs

	task automatic t_level;
		wr(8'h00, 32'h0000_3000);
		wr(8'h04, 32'h0);
		wr(8'h08, 32'h2300_0000);
		wr(8'h14, 32'h4);
		wr(8'h28, 32'h0);
		for (int k = 1; k <= 5; k++) begin
			cp(1'b0, 1);
			pc(k == 4);
		end
		rdc(8'h28, 32'h0);
		cp(1'b1, 1);
		rdc(8'h28, 32'h4);
		wr(8'h00, 32'h0000_2000);
		pc(1'b0);
		cp(1'b1, 1);
		pc(1'b1);
	endtask : t_level

	task automatic t_pulse;
		int h;
		wr(8'h00, 32'h0000_3000);
		wr(8'h08, 32'h2380_0000);
		wr(8'h28, 32'h3);
		cp(1'b0, 1);
		h = hits;
		cp(1'b0, 1);
		chk(hits - h, 32'h2);
		wr(8'h28, 32'h1);
		h = hits;
		cp(1'b1, 1);
		chk(hits - h, 32'h2);
		h = hits;
		wr(8'h28, 32'h2);
		wr(8'h28, 32'h0);
		pc(1'b0);
		chk(hits - h, 32'h0);
		wr(8'h08, 32'h0380_0000);
		wr(8'h28, 32'h4);
		h = hits;
		cp(1'b0, 1);
		chk(hits - h, 32'h0);
	endtask : t_pulse

	task automatic t_oneway;
		wr(8'h08, 32'h2700_0000);
		wr(8'h14, 32'h4);
		wr(8'h28, 32'h0);
		cp(1'b1, 1);
		pc(1'b0);
		wr(8'h28, 32'h3);
		cp(1'b0, 1);
		pc(1'b1);
		wr(8'h08, 32'h2b00_0000);
		pc(1'b0);
		wr(8'h28, 32'h0);
		cp(1'b1, 1);
		pc(1'b1);
	endtask : t_oneway

	task automatic t_enc;
		wr(8'h04, 32'h0000_1000);
		wr(8'h08, 32'h2300_0000);
		wr(8'h14, 32'hffff);
		for (int m = 0; m < 4; m++) begin
			wr(8'h00, 32'(m) << 20);
			wr(8'h28, 32'd100);
			es((m == 3) ? 1 : 0, 4);
			rdc(8'h28, (m == 3) ? 32'd102 : 32'd100 + (32'h1 << m));
		end
		wr(8'h00, 32'h0060_0000);
		wr(8'h28, 32'd100);
		es(0, 4);
		rdc(8'h28, 32'd96);
		rdc(8'h0c, 32'h0);
	endtask : t_enc

	task automatic t_err;
		lag <= 4'h0;
		wr(8'h18, 32'h0001_0000);
		wr(8'h1c, 32'hffff_ffff);
		es(2, 1);
		rdc(8'h0c, 32'h0001_0000, 32'h0001_0000);
		rdc(8'h1c, 32'h0001_0000, 32'h0001_0000);
		chk({31'h0, irq_n}, 32'h0);
		wr(8'h18, 32'h0);
		pc(1'b0);
		chk({31'h0, irq_n}, 32'h1);
		wr(8'h1c, 32'h0001_0000);
		rdc(8'h0c, 32'h0001_0000, 32'h0001_0000);
	endtask : t_err

	task automatic t_defl;
		wr(8'h20, 32'h22);
		wr(8'h10, 32'h2);
		wr(8'h1c, 32'hffff_ffff);
		rdc(8'h24, 32'h0);
		cp(1'b0, 2);
		rdc(8'h1c, 32'h0, 32'h400);
		cp(1'b0, 1);
		rdc(8'h24, 32'h3);
		rdc(8'h1c, 32'h400, 32'h400);
		chk({31'h0, irq_n}, 32'h1);
		wr(8'h18, 32'h400);
		pc(1'b0);
		chk({31'h0, irq_n}, 32'h0);
		wr(8'h20, 32'h22);
		rdc(8'h24, 32'h0);
		wr(8'h1c, 32'h400);
		pc(1'b0);
		chk({31'h0, irq_n}, 32'h1);
	endtask : t_defl

	task automatic t_src;
		int c0;
		logic [31:0] v0;
		wr(8'h04, 32'h0000_3000);
		rdc(8'h28, 32'h0, 32'h0);
		c0 = cyc;
		v0 = rd;
		repeat (100) @(posedge clk);
		rdc(8'h28, 32'h0, 32'h0);
		// read latency is the same both times, so only the span matters
		chk({31'h0, (rd - v0) * 2 + 2 >= cyc - c0 && (rd - v0) * 2 <= cyc - c0 + 2}, 32'h1);
		wr(8'h04, 32'h0000_2000);
		wr(8'h28, 32'h0);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			pulser <= (i == 0) ? 2'h1 : (i == 1) ? 2'h3 : (i == 2) ? 2'h2 : 2'h0;
			repeat (10) @(posedge clk);
		end
		rdc(8'h28, 32'h4);
	endtask : t_src

	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_regs;
		t_level;
		t_pulse;
		t_oneway;
		t_enc;
		t_err;
		t_defl;
		t_src;
		finish_test;
	end

	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		finish_test;
	end
endmodule : tb
